// ### rtl/gpio_port.v
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.vh"

// ------------------------------------------------
// One port pin: drive, pull-up, read, compare
// ------------------------------------------------
module pin_slice
#(
  parameter HAS_PULLUP = 1
)
(
  input  wire periph_en_i,
  input  wire periph_out_i,
  input  wire periph_oe_i,
  input  wire latch_i,
  input  wire dir_i,
  input  wire level_i,
  input  wire analog_i,
  input  wire mute_i,
  input  wire pullup_en_i,
  input  wire pullup_off_i,
  input  wire pullup_force_i,
  input  wire last_i,
  input  wire change_en_i,
  output wire pin_o,
  output wire pin_oe_o,
  output wire pullup_o,
  output wire digital_o,
  output wire mismatch_o
);

wire own_pin;
wire pullup_sel;

// Peripheral owns both value and enable
assign own_pin    = ~periph_en_i;
assign pin_o      = own_pin ? latch_i : periph_out_i;
assign pin_oe_o   = own_pin ? ~dir_i : periph_oe_i;
// Analog select only gates the input side
assign digital_o  = level_i & ~analog_i & ~mute_i;
assign pullup_sel = pullup_en_i & dir_i & ~pullup_off_i;
// Pin without a pull-up bit follows its reset use
assign pullup_o   = (HAS_PULLUP != 0) ? pullup_sel : pullup_force_i;
assign mismatch_o = (digital_o ^ last_i) & change_en_i;
endmodule // pin_slice

module gpio_port
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        por_i,
  input  wire [3:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  input  wire [5:0]  pin_i,
  output wire [5:0]  pin_o,
  output wire [5:0]  pin_oe_o,
  output wire [5:0]  pullup_o,
  input  wire [5:0]  periph_en_i,
  input  wire [5:0]  periph_out_i,
  input  wire [5:0]  periph_oe_i,
  input  wire        ext_reset_pin_enable_i,
  input  wire        crystal_mode_i,
  output wire        change_irq_o,
  output wire        wake_o
);

// ------------------------------------------------
// Registers
// ------------------------------------------------
reg [5:0] sync1_reg;
reg [5:0] sync2_reg;
reg [5:0] latch_reg;
reg [5:0] dir_reg;
reg [7:0] analog_select_low_reg;
reg [5:0] pullup_reg;
reg [5:0] ioc_reg;
reg       pudis_reg;
reg       gie_reg;
reg       flag_reg;
reg [5:0] last_reg;
wire [5:0] dir_eff;
wire [5:0] digital_in;
wire [5:0] mismatch;
wire       port_acc;
wire [5:0] mute;
wire [5:0] pullup_force;
wire [5:0] pullup_en;
wire       wr_port;
wire       wr_dir;
wire       wr_analog_select_low;
wire       wr_pullup;
wire       wr_ioc;
wire       wr_ctrl;
reg  [7:0] rdata_next;

// No reset here: a pin reset must not fake a mismatch
always @(posedge clk_i)
begin
  sync1_reg <= pin_i;
  sync2_reg <= sync1_reg;
end

// ------------------------------------------------
// Pin control
// ------------------------------------------------
assign dir_eff = (dir_reg | `INONLY_ONEHOT)
                 | (crystal_mode_i ? `XTAL_DIR_MASK : `ZERO6);
// Pin 3 reads 0 and is pulled up while it serves as reset
assign mute         = ext_reset_pin_enable_i ? `INONLY_ONEHOT : `ZERO6;
assign pullup_force = mute;
assign pullup_en    = pullup_reg & `PIN_MASK;
assign port_acc     = (rd_i | wr_i) && (addr_i == `ADDR_PORT);
assign change_irq_o = flag_reg & gie_reg;
assign wake_o       = flag_reg;

// ------------------------------------------------
// Pin slices; analog select bits 5:0 map to pins
// ------------------------------------------------
pin_slice
#(
  .HAS_PULLUP     (1)
)
i_pin_slice_0
(
  .periph_en_i    (periph_en_i[0]),
  .periph_out_i   (periph_out_i[0]),
  .periph_oe_i    (periph_oe_i[0]),
  .latch_i        (latch_reg[0]),
  .dir_i          (dir_eff[0]),
  .level_i        (sync2_reg[0]),
  .analog_i       (analog_select_low_reg[0]),
  .mute_i         (mute[0]),
  .pullup_en_i    (pullup_en[0]),
  .pullup_off_i   (pudis_reg),
  .pullup_force_i (pullup_force[0]),
  .last_i         (last_reg[0]),
  .change_en_i    (ioc_reg[0]),
  .pin_o          (pin_o[0]),
  .pin_oe_o       (pin_oe_o[0]),
  .pullup_o       (pullup_o[0]),
  .digital_o      (digital_in[0]),
  .mismatch_o     (mismatch[0])
);

pin_slice
#(
  .HAS_PULLUP     (1)
)
i_pin_slice_1
(
  .periph_en_i    (periph_en_i[1]),
  .periph_out_i   (periph_out_i[1]),
  .periph_oe_i    (periph_oe_i[1]),
  .latch_i        (latch_reg[1]),
  .dir_i          (dir_eff[1]),
  .level_i        (sync2_reg[1]),
  .analog_i       (analog_select_low_reg[1]),
  .mute_i         (mute[1]),
  .pullup_en_i    (pullup_en[1]),
  .pullup_off_i   (pudis_reg),
  .pullup_force_i (pullup_force[1]),
  .last_i         (last_reg[1]),
  .change_en_i    (ioc_reg[1]),
  .pin_o          (pin_o[1]),
  .pin_oe_o       (pin_oe_o[1]),
  .pullup_o       (pullup_o[1]),
  .digital_o      (digital_in[1]),
  .mismatch_o     (mismatch[1])
);

pin_slice
#(
  .HAS_PULLUP     (1)
)
i_pin_slice_2
(
  .periph_en_i    (periph_en_i[2]),
  .periph_out_i   (periph_out_i[2]),
  .periph_oe_i    (periph_oe_i[2]),
  .latch_i        (latch_reg[2]),
  .dir_i          (dir_eff[2]),
  .level_i        (sync2_reg[2]),
  .analog_i       (analog_select_low_reg[2]),
  .mute_i         (mute[2]),
  .pullup_en_i    (pullup_en[2]),
  .pullup_off_i   (pudis_reg),
  .pullup_force_i (pullup_force[2]),
  .last_i         (last_reg[2]),
  .change_en_i    (ioc_reg[2]),
  .pin_o          (pin_o[2]),
  .pin_oe_o       (pin_oe_o[2]),
  .pullup_o       (pullup_o[2]),
  .digital_o      (digital_in[2]),
  .mismatch_o     (mismatch[2])
);

// Input-only pin: no pull-up bit, never driven by the latch
pin_slice
#(
  .HAS_PULLUP     (0)
)
i_pin_slice_3
(
  .periph_en_i    (periph_en_i[3]),
  .periph_out_i   (periph_out_i[3]),
  .periph_oe_i    (periph_oe_i[3]),
  .latch_i        (latch_reg[3]),
  .dir_i          (dir_eff[3]),
  .level_i        (sync2_reg[3]),
  .analog_i       (analog_select_low_reg[3]),
  .mute_i         (mute[3]),
  .pullup_en_i    (pullup_en[3]),
  .pullup_off_i   (pudis_reg),
  .pullup_force_i (pullup_force[3]),
  .last_i         (last_reg[3]),
  .change_en_i    (ioc_reg[3]),
  .pin_o          (pin_o[3]),
  .pin_oe_o       (pin_oe_o[3]),
  .pullup_o       (pullup_o[3]),
  .digital_o      (digital_in[3]),
  .mismatch_o     (mismatch[3])
);

pin_slice
#(
  .HAS_PULLUP     (1)
)
i_pin_slice_4
(
  .periph_en_i    (periph_en_i[4]),
  .periph_out_i   (periph_out_i[4]),
  .periph_oe_i    (periph_oe_i[4]),
  .latch_i        (latch_reg[4]),
  .dir_i          (dir_eff[4]),
  .level_i        (sync2_reg[4]),
  .analog_i       (analog_select_low_reg[4]),
  .mute_i         (mute[4]),
  .pullup_en_i    (pullup_en[4]),
  .pullup_off_i   (pudis_reg),
  .pullup_force_i (pullup_force[4]),
  .last_i         (last_reg[4]),
  .change_en_i    (ioc_reg[4]),
  .pin_o          (pin_o[4]),
  .pin_oe_o       (pin_oe_o[4]),
  .pullup_o       (pullup_o[4]),
  .digital_o      (digital_in[4]),
  .mismatch_o     (mismatch[4])
);

pin_slice
#(
  .HAS_PULLUP     (1)
)
i_pin_slice_5
(
  .periph_en_i    (periph_en_i[5]),
  .periph_out_i   (periph_out_i[5]),
  .periph_oe_i    (periph_oe_i[5]),
  .latch_i        (latch_reg[5]),
  .dir_i          (dir_eff[5]),
  .level_i        (sync2_reg[5]),
  .analog_i       (analog_select_low_reg[5]),
  .mute_i         (mute[5]),
  .pullup_en_i    (pullup_en[5]),
  .pullup_off_i   (pudis_reg),
  .pullup_force_i (pullup_force[5]),
  .last_i         (last_reg[5]),
  .change_en_i    (ioc_reg[5]),
  .pin_o          (pin_o[5]),
  .pin_oe_o       (pin_oe_o[5]),
  .pullup_o       (pullup_o[5]),
  .digital_o      (digital_in[5]),
  .mismatch_o     (mismatch[5])
);

// ------------------------------------------------
// Write decode
// ------------------------------------------------
assign wr_port   = wr_i && (addr_i == `ADDR_PORT);
assign wr_dir    = wr_i && (addr_i == `ADDR_DIR);
assign wr_analog_select_low  = wr_i && (addr_i == `ADDR_ANALOG_SELECT_LOW);
assign wr_pullup = wr_i && (addr_i == `ADDR_PULLUP);
assign wr_ioc    = wr_i && (addr_i == `ADDR_IOC);
assign wr_ctrl   = wr_i && (addr_i == `ADDR_CTRL);

// ------------------------------------------------
// Config registers, power-on reset only
// ------------------------------------------------
always @(posedge clk_i or posedge por_i)
begin
  if (por_i)
  begin
    dir_reg    <= `RST_DIR;
    analog_select_low_reg  <= `RST_ANALOG_SELECT_LOW;
    pullup_reg <= `RST_PULLUP;
    ioc_reg    <= `RST_IOC;
    pudis_reg  <= `RST_PUDIS;
    gie_reg    <= `RST_GIE;
    latch_reg  <= `RST_LATCH;
    last_reg   <= `RST_LAST;
  end
  else
  begin
    // Last-read latch ignores rst_i so a mismatch survives
    if (port_acc)
      last_reg <= digital_in;
    // The whole byte is the modify step; the latch is the store
    if (wr_port)
      latch_reg  <= wdata_i[5:0];
    if (wr_dir)
      dir_reg    <= wdata_i[5:0];
    if (wr_analog_select_low)
      analog_select_low_reg  <= wdata_i;
    if (wr_pullup)
      pullup_reg <= wdata_i[5:0] & `PIN_MASK;
    if (wr_ioc)
      ioc_reg    <= wdata_i[5:0];
    if (wr_ctrl)
    begin
      pudis_reg <= wdata_i[`CTRL_PUDIS];
      gie_reg   <= wdata_i[`CTRL_GIE];
    end
  end
end

// ------------------------------------------------
// Change flag and read data
// ------------------------------------------------
always @(posedge clk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    flag_reg <= `RST_FLAG;
    rdata_o  <= `RST_RDATA;
  end
  else
  begin
    // Set beats a software clear; a port access blocks the set
    if (|mismatch && !port_acc)
      flag_reg <= 1'b1;
    else if (wr_ctrl && !wdata_i[`CTRL_FLAG])
      flag_reg <= 1'b0;
    rdata_o <= rdata_next;
  end
end

// ------------------------------------------------
// Read multiplexer
// ------------------------------------------------
// Idle cycles return zero so stale data never lingers
always @*
begin
  rdata_next = `RST_RDATA;
  if (rd_i)
  begin
    case (addr_i)
      `ADDR_PORT:   rdata_next = {2'b00, digital_in};
      `ADDR_DIR:    rdata_next = {2'b00, dir_eff};
      `ADDR_ANALOG_SELECT_LOW:  rdata_next = analog_select_low_reg;
      `ADDR_PULLUP: rdata_next = {2'b00, pullup_reg};
      `ADDR_IOC:    rdata_next = {2'b00, ioc_reg};
      `ADDR_CTRL:   rdata_next = {5'h00, gie_reg, pudis_reg, flag_reg};
      default:      rdata_next = `RST_RDATA;
    endcase
  end
end
endmodule // gpio_port
`default_nettype wire

// ### pkg/gpio_port_map.vh
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH
`define ADDR_PORT      4'h0
`define ADDR_DIR       4'h1
`define ADDR_ANALOG_SELECT_LOW     4'h2
`define ADDR_PULLUP    4'h3
`define ADDR_IOC       4'h4
`define ADDR_CTRL      4'h5
`define RST_DIR        6'h3f
`define RST_ANALOG_SELECT_LOW      8'hff
`define RST_PULLUP     6'h37
`define RST_IOC        6'h00
`define PIN_MASK       6'h37
`define XTAL_DIR_MASK  6'h30
`define BIT_INONLY     3
`define CTRL_FLAG      0
`define CTRL_PUDIS     1
`define CTRL_GIE       2
`define RST_LATCH      6'h00
`define RST_LAST       6'h00
`define RST_PUDIS      1'b1
`define RST_GIE        1'b0
`define RST_FLAG       1'b0
`define RST_RDATA      8'h00
`define INONLY_ONEHOT  6'h08
`define ZERO6          6'h00
`endif

// ### tb/gpio_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_chk(
  input wire logic       clk_i, rst_i, rd_i, wr_i, change_irq_o, wake_o,
  input wire logic       ext_reset_pin_enable_i, crystal_mode_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic [5:0] pin_o, pin_oe_o, pullup_o,
  input wire logic [5:0] periph_en_i, periph_out_i, periph_oe_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_hi_zero: assert property (rdata_o[7:6] == 0)
    else $error("hi bits");
  chk_pu_three: assert property (pullup_o[3] == ext_reset_pin_enable_i)
    else $error("pu3");
  chk_periph_own: assert property ((((pin_o ^ periph_out_i)
    | (pin_oe_o ^ periph_oe_i)) & periph_en_i) == 0) else $error("periph");
  chk_irq_flag: assert property (change_irq_o |-> wake_o)
    else $error("irq");
  chk_ext_reset_pin_rd: assert property (rd_i && addr_i == 0
    && ext_reset_pin_enable_i |=> !rdata_o[3]) else $error("rd3");
  chk_dir_three: assert property (rd_i && addr_i == 1 |=> rdata_o[3])
    else $error("dir3");
  chk_xtal_dir: assert property (rd_i && addr_i == 1
    && crystal_mode_i |=> &rdata_o[5:4]) else $error("xtal");
  chk_flag_hold: assert property (wake_o && !wr_i |=> wake_o)
    else $error("flag");
  cover property (change_irq_o);
  cover property (rd_i && addr_i == 0);
  cover property (|periph_en_i);
endmodule // gpio_port_chk
bind gpio_port gpio_port_chk i_chk(.*);
`default_nettype wire

// ### tb/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model(
  input wire logic [5:0] pin_o, pin_oe_o, ext_v,
  output logic     [5:0] pin_i);
  // Driver wins, otherwise outside source holds the line
  assign pin_i = pin_oe_o & pin_o | ~pin_oe_o & ext_v;
endmodule // pin_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin error_cnt++;\
 $display("BAD %0t %h/%h", $time, a, b); end end
module tb;
  logic clk_i = 0, rst_i = 1, por_i = 1, wr_i = 0, rd_i = 0, change_irq_o;
  logic ext_reset_pin_enable_i = 0, crystal_mode_i = 0, wake_o;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, q;
  logic [5:0] pin_o, pin_oe_o, pullup_o, v = 0, d, l, periph_en_i = 0;
  logic [5:0] periph_out_i = 0, periph_oe_i = 0;
  wire  [5:0] pin_i;
  int error_cnt = 0, samples_checked = 0, cyc = 0, i, seed = 32'hea1a_ab8b;
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 4000) begin error_cnt++; complete_run; end
  gpio_port i_gpio_port(.*);
  pin_model i_pin_model(.pin_o, .pin_oe_o, .ext_v(v), .pin_i);
  task wr(input [3:0] a, input [7:0] x);
    @(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, x, 1'b1};
    @(posedge clk_i) wr_i <= 0;
  endtask
  task rd(input [3:0] a);
    @(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i) rd_i <= 0;
    @(negedge clk_i) q = rdata_o;
  endtask
  task complete_run;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    {rst_i, por_i} <= 0;
    rd(1); `CHK(q, 8'h3f)
    rd(4); `CHK(q, 8'h00)
    v <= 6'h2a; rd(0); `CHK(q, 8'h00)
    wr(2, 0); wr(5, 8'h04);
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i)
        {ext_reset_pin_enable_i, crystal_mode_i} <= 2'($random(seed));
      d = 6'($random(seed)); l = 6'($random(seed));
      wr(1, {2'b11, d}); wr(0, {2'b11, l}); v <= 6'($random(seed));
      repeat (3) @(posedge clk_i);
      d = d | 6'h08 | (crystal_mode_i ? 6'h30 : 6'h00);
      rd(1); `CHK(q, {2'b00, d})
      l = (d & v | ~d & l) & ~(ext_reset_pin_enable_i ? 6'h08 : 6'h00);
      rd(0); `CHK(q, {2'b00, l})
      `CHK(pullup_o, {d[5:4], ext_reset_pin_enable_i, d[2:0]})
    end
    wr(1, 8'h3f); wr(4, 8'h01); rd(0); v[0] <= ~v[0];
    repeat (4) @(posedge clk_i); `CHK(change_irq_o, 1'b1)
    rst_i <= 1; @(posedge clk_i) rst_i <= 0;
    repeat (4) @(posedge clk_i); `CHK(wake_o, 1'b1)
    rd(0); wr(5, 8'h04);
    @(negedge clk_i) `CHK(wake_o, 1'b0)
    v[1] <= ~v[1];
    repeat (4) @(posedge clk_i); `CHK(wake_o, 1'b0)
    for (i = 0; i < 30; i++) @(posedge clk_i)
      {periph_en_i, periph_out_i, periph_oe_i} <= 18'($random(seed));
    complete_run;
  end
endmodule // tb
`default_nettype wire
